/* File: rtl/via_pkg.sv */
// Constants, register map and source tables of the vectored interrupt aggregator.
// Assumes one 200 MHz clock and a classic Wishbone master with 32-bit data.
// Operation
// - Up to 1024 interrupt sources, one status bit each
// - Sources grouped, at most 32 per group
// - Each source has one of four priorities
// - Aggregated or disaggregated mode chosen per group
// - Aggregated: one programmable vector offset per group
// - Disaggregated: one programmable vector offset per source
// - Processor receives handler address offset, not number
// - All groups interrupt except the automatic wake group
// - Events synchronized to local clock before priority
// - Only enabled sources reach the priority encoder
// - Wake-capable sources drive an asynchronous wake output
// - Groups 16 and 22 hold wake-only events
// - Legacy wake group raises wake and vector
// - Automatic wake group clears itself without firmware
// - Wake-only bits set by bus or port activity
// - Debugger activity sets the debug wake bit
// - GPIO sources in groups 8 and 9; wake-capable are bits 22:0 of group 8 and bits 30:0 of group 9
// - Status, set/clear enable and result per source
// - Outputs: request, vector offset, requested priority level
package via_pkg;
   localparam int NUM_GROUPS = 32;
   localparam int GROUP_BITS = 32;
   localparam int NUM_SRC = 1024;
   localparam int IDX_W = 10;
   localparam int VEC_W = 18;
   localparam int PRIO_W = 2;
   localparam int ADR_W = 14;
   localparam int LEGACY_WAKE_GROUP = 16;
   localparam int AUTO_WAKE_GROUP = 22;
   localparam int DEBUG_WAKE_BIT = 8;
   localparam int GPIO_A_GROUP = 8;
   localparam int GPIO_B_GROUP = 9;

   // Byte offsets inside one group block
   localparam logic [4:0] OFF_SRC = 5'h00;
   localparam logic [4:0] OFF_EN_SET = 5'h04;
   localparam logic [4:0] OFF_EN_CLR = 5'h08;
   localparam logic [4:0] OFF_RESULT = 5'h0c;
   localparam logic [4:0] OFF_MODE = 5'h10;
   localparam logic [4:0] OFF_AGG_VEC = 5'h14;
   localparam logic [4:0] OFF_PRIO_LO = 5'h18;
   localparam logic [4:0] OFF_PRIO_HI = 5'h1c;
   // Regions selected by address bits 13:12
   localparam logic [1:0] REGION_GROUP = 2'h0;
   localparam logic [1:0] REGION_VEC = 2'h1;
   localparam logic [ADR_W-1:0] ADDR_STATUS = 14'h2000;
   localparam int STAT_REQ_BIT = 31;
   localparam int STAT_LVL_LSB = 24;

   localparam logic [GROUP_BITS-1:0] RST_EN = 32'h0;
   localparam logic [NUM_GROUPS-1:0] RST_MODE = 32'h0;
   localparam logic [VEC_W-1:0] RST_VEC = 18'h0;
   localparam logic [PRIO_W-1:0] RST_PRIO = 2'h0;

   localparam logic [GROUP_BITS-1:0] GPIO_A_WAKE = 32'h007f_ffff;
   localparam logic [GROUP_BITS-1:0] GPIO_B_WAKE = 32'h7fff_ffff;
   localparam logic [GROUP_BITS-1:0] WAKE_ONLY_MASK = 32'h0000_03ff;

   function automatic logic [NUM_SRC-1:0] wake_map();
      logic [NUM_SRC-1:0] m;
      m = '0;
      m[GPIO_A_GROUP*GROUP_BITS +: GROUP_BITS] = GPIO_A_WAKE;
      m[GPIO_B_GROUP*GROUP_BITS +: GROUP_BITS] = GPIO_B_WAKE;
      m[LEGACY_WAKE_GROUP*GROUP_BITS +: GROUP_BITS] = WAKE_ONLY_MASK;
      m[AUTO_WAKE_GROUP*GROUP_BITS +: GROUP_BITS] = WAKE_ONLY_MASK;
      return m;
   endfunction

   localparam logic [NUM_SRC-1:0] WAKE_MAP = wake_map();
   localparam logic [NUM_SRC-1:0] AUTO_MAP = {{(NUM_SRC-AUTO_WAKE_GROUP*GROUP_BITS-GROUP_BITS){1'b0}},
      {GROUP_BITS{1'b1}}, {(AUTO_WAKE_GROUP*GROUP_BITS){1'b0}}};
endpackage

/* File: rtl/via_top.sv */
// Vectored interrupt aggregator: source capture, enables, priority pick and vector output.
// Assumes source lines are asynchronous to clk and a classic Wishbone master on the register side.
`timescale 1ns/1ps
`default_nettype none
module via_top (
   input wire logic clk,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [via_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [via_pkg::NUM_SRC-1:0] src_event,
   output logic irq_req,
   output logic [via_pkg::VEC_W-1:0] irq_vector,
   output logic [via_pkg::PRIO_W-1:0] requested_priority_level,
   output logic wake_event
);
   localparam int NS = via_pkg::NUM_SRC;
   localparam int GB = via_pkg::GROUP_BITS;
   localparam int AG = via_pkg::AUTO_WAKE_GROUP;

   logic [NS-1:0] src_meta;
   logic [NS-1:0] src_sync;
   logic [NS-1:0] status;
   logic [NS-1:0] enable;
   logic [NS-1:0] result;
   logic [NS-1:0] clr_flat;
   logic [NS*via_pkg::PRIO_W-1:0] prio;
   logic [via_pkg::NUM_GROUPS-1:0] mode;
   logic [via_pkg::VEC_W-1:0] agg_vec [via_pkg::NUM_GROUPS];
   logic [via_pkg::VEC_W-1:0] src_vec [NS];
   logic bus_req;
   logic wr;
   logic wr_grp;
   logic [4:0] grp_sel;
   logic [4:0] grp_off;
   logic [31:0] wmask;
   logic [31:0] rdata;
   logic next_req;
   logic [via_pkg::PRIO_W-1:0] next_lvl;
   logic [via_pkg::IDX_W-1:0] next_idx;
   logic [via_pkg::VEC_W-1:0] next_vec;

   function automatic logic [31:0] byte_mask(input logic [3:0] sel);
      return {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
      return (old & ~m) | (d & m);
   endfunction

   // Two flops per source line; nothing but the second flop reads src_meta
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         src_meta <= '0;
         src_sync <= '0;
      end else begin
         src_meta <= src_event;
         src_sync <= src_meta;
      end
   end

   // Bus decode: registers change at the edge where the master sees ack
   assign bus_req = wb_cyc_i & wb_stb_i;
   assign wr = bus_req & wb_ack_o & wb_we_i;
   assign grp_sel = wb_adr_i[9:5];
   assign grp_off = wb_adr_i[4:0];
   assign wr_grp = wr && (wb_adr_i[13:10] == 4'h0);
   assign wmask = byte_mask(wb_sel_i);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= bus_req & ~wb_ack_o;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wb_dat_o <= 32'h0;
      end else if (bus_req && !wb_ack_o) begin
         wb_dat_o <= rdata;
      end
   end

   // Write-one-to-clear on the status word
   always_comb begin
      clr_flat = '0;
      if (wr_grp && grp_off == via_pkg::OFF_SRC) begin
         clr_flat[int'(grp_sel)*GB +: GB] = wb_dat_i & wmask;
      end
   end

   // A new event in the clearing cycle survives: set is ORed in after the clear
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         status <= '0;
      end else begin
         status <= (status & ~clr_flat) | src_sync;
         // The automatic group follows its lines and drops on its own, no firmware clear needed
         status[AG*GB +: GB] <= src_sync[AG*GB +: GB];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enable <= {via_pkg::NUM_GROUPS{via_pkg::RST_EN}};
      end else if (wr_grp && grp_off == via_pkg::OFF_EN_SET) begin
         enable[int'(grp_sel)*GB +: GB] <= enable[int'(grp_sel)*GB +: GB] | (wb_dat_i & wmask);
      end else if (wr_grp && grp_off == via_pkg::OFF_EN_CLR) begin
         enable[int'(grp_sel)*GB +: GB] <= enable[int'(grp_sel)*GB +: GB] & ~(wb_dat_i & wmask);
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode <= via_pkg::RST_MODE;
      end else if (wr_grp && grp_off == via_pkg::OFF_MODE && wb_sel_i[0]) begin
         mode[grp_sel] <= wb_dat_i[0];
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int g = 0; g < via_pkg::NUM_GROUPS; g++) begin
            agg_vec[g] <= via_pkg::RST_VEC;
         end
      end else if (wr_grp && grp_off == via_pkg::OFF_AGG_VEC) begin
         agg_vec[grp_sel] <= via_pkg::VEC_W'(merge(32'(agg_vec[grp_sel]), wb_dat_i, wmask));
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NS; i++) begin
            src_vec[i] <= via_pkg::RST_VEC;
         end
      end else if (wr && wb_adr_i[13:12] == via_pkg::REGION_VEC) begin
         src_vec[wb_adr_i[11:2]] <= via_pkg::VEC_W'(merge(32'(src_vec[wb_adr_i[11:2]]), wb_dat_i, wmask));
      end
   end

   // Sixteen 2-bit priorities per word, two words per group
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prio <= {NS{via_pkg::RST_PRIO}};
      end else if (wr_grp && grp_off == via_pkg::OFF_PRIO_LO) begin
         prio[int'(grp_sel)*64 +: 32] <= merge(prio[int'(grp_sel)*64 +: 32], wb_dat_i, wmask);
      end else if (wr_grp && grp_off == via_pkg::OFF_PRIO_HI) begin
         prio[int'(grp_sel)*64+32 +: 32] <= merge(prio[int'(grp_sel)*64+32 +: 32], wb_dat_i, wmask);
      end
   end

   assign result = status & enable;

   always_comb begin
      rdata = 32'h0;
      if (wb_adr_i[13:10] == 4'h0) begin
         case (grp_off)
            via_pkg::OFF_SRC: begin
               rdata = status[int'(grp_sel)*GB +: GB];
            end
            via_pkg::OFF_EN_SET, via_pkg::OFF_EN_CLR: begin
               rdata = enable[int'(grp_sel)*GB +: GB];
            end
            via_pkg::OFF_RESULT: begin
               rdata = result[int'(grp_sel)*GB +: GB];
            end
            via_pkg::OFF_MODE: begin
               rdata = {31'h0, mode[grp_sel]};
            end
            via_pkg::OFF_AGG_VEC: begin
               rdata = 32'(agg_vec[grp_sel]);
            end
            via_pkg::OFF_PRIO_LO: begin
               rdata = prio[int'(grp_sel)*64 +: 32];
            end
            via_pkg::OFF_PRIO_HI: begin
               rdata = prio[int'(grp_sel)*64+32 +: 32];
            end
            default: begin
               rdata = 32'h0;
            end
         endcase
      end else if (wb_adr_i[13:12] == via_pkg::REGION_VEC) begin
         rdata = 32'(src_vec[wb_adr_i[11:2]]);
      end else if (wb_adr_i == via_pkg::ADDR_STATUS) begin
         rdata[via_pkg::STAT_REQ_BIT] = irq_req;
         rdata[via_pkg::STAT_LVL_LSB +: via_pkg::PRIO_W] = requested_priority_level;
         rdata[via_pkg::VEC_W-1:0] = irq_vector;
      end
   end
   // Walk downward so a lower index of equal priority replaces a higher one
   always_comb begin
      next_req = 1'b0;
      next_lvl = '0;
      next_idx = '0;
      for (int i = NS - 1; i >= 0; i--) begin
         if (result[i] && !via_pkg::AUTO_MAP[i] &&
             (!next_req || prio[i*2 +: 2] >= next_lvl)) begin
            next_req = 1'b1;
            next_lvl = prio[i*2 +: 2];
            next_idx = via_pkg::IDX_W'(i);
         end
      end
      next_vec = mode[next_idx[9:5]] ? src_vec[next_idx] : agg_vec[next_idx[9:5]];
   end

   // Legacy wake group is an ordinary group here, so it interrupts as well as wakes
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_req <= 1'b0;
         irq_vector <= via_pkg::RST_VEC;
         requested_priority_level <= via_pkg::RST_PRIO;
      end else begin
         irq_req <= next_req;
         irq_vector <= next_req ? next_vec : via_pkg::RST_VEC;
         requested_priority_level <= next_req ? next_lvl : via_pkg::RST_PRIO;
      end
   end

   // Must work with the clock stopped, so this path is unregistered by design
   always_comb begin
      wake_event = |(src_event & enable & via_pkg::WAKE_MAP);
   end

   logic any_top;
   always_comb begin
      any_top = 1'b0;
      for (int i = 0; i < NS; i++) begin
         if (result[i] && !via_pkg::AUTO_MAP[i] && (&prio[i*2 +: 2])) begin
            any_top = 1'b1;
         end
      end
   end

   property p_req_cause;
      @(posedge clk) disable iff (!rstn) irq_req |-> $past(|(result & ~via_pkg::AUTO_MAP));
   endproperty
   a_req_cause: assert property (p_req_cause) else $error("request without enabled source");

   property p_auto_silent;
      @(posedge clk) disable iff (!rstn) !(|(result & ~via_pkg::AUTO_MAP)) |=> !irq_req;
   endproperty
   a_auto_silent: assert property (p_auto_silent) else $error("request from automatic group");

   property p_auto_clear;
      @(posedge clk) disable iff (!rstn) (src_sync[AG*GB +: GB] == '0) |=> (status[AG*GB +: GB] == '0);
   endproperty
   a_auto_clear: assert property (p_auto_clear) else $error("automatic group bit not cleared");

   sequence s_src_held;
      src_event[160] [*3];
   endsequence
   property p_sync_lat;
      @(posedge clk) disable iff (!rstn) s_src_held |=> status[160];
   endproperty
   a_sync_lat: assert property (p_sync_lat) else $error("source not captured after two flops");

   property p_set_wins;
      @(posedge clk) disable iff (!rstn) (clr_flat[1023] && src_sync[1023]) |=> status[1023];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("event lost during clear");

   property p_top_level;
      @(posedge clk) disable iff (!rstn) any_top |=> (requested_priority_level == 2'h3);
   endproperty
   a_top_level: assert property (p_top_level) else $error("highest priority not chosen");

   property p_legacy_irq;
      @(posedge clk) disable iff (!rstn)
         (result[via_pkg::LEGACY_WAKE_GROUP*GB +: GB] != '0) |=> irq_req;
   endproperty
   a_legacy_irq: assert property (p_legacy_irq) else $error("legacy wake group gave no request");

   sequence s_en_set0;
      wr_grp && grp_off == via_pkg::OFF_EN_SET && wb_sel_i[0] && wb_dat_i[0];
   endsequence
   property p_en_set;
      @(posedge clk) disable iff (!rstn) s_en_set0 |=> enable[int'($past(grp_sel))*GB] ##0
         (result[int'($past(grp_sel))*GB] == status[int'($past(grp_sel))*GB]);
   endproperty
   a_en_set: assert property (p_en_set) else $error("enable set did not take effect");

   property p_ack_pulse;
      @(posedge clk) disable iff (!rstn) wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge longer than one cycle");

   property p_ack_cause;
      @(posedge clk) disable iff (!rstn) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without request");

   property p_rd_data;
      @(posedge clk) disable iff (!rstn) wb_ack_o |-> (wb_dat_o == $past(rdata));
   endproperty
   a_rd_data: assert property (p_rd_data) else $error("read data not from addressed register");

   property p_idle_zero;
      @(posedge clk) disable iff (!rstn) !irq_req |-> (irq_vector == '0 && requested_priority_level == '0);
   endproperty
   a_idle_zero: assert property (p_idle_zero) else $error("offset or level shown without request");

   property p_req_follow;
      @(posedge clk) disable iff (!rstn) (|(result & ~via_pkg::AUTO_MAP)) |=> irq_req;
   endproperty
   a_req_follow: assert property (p_req_follow) else $error("pending source gave no request");

   property p_win_enabled;
      @(posedge clk) disable iff (!rstn) next_req |-> (result[next_idx] && !via_pkg::AUTO_MAP[next_idx]);
   endproperty
   a_win_enabled: assert property (p_win_enabled) else $error("winner not an enabled source");

   property p_lvl_match;
      @(posedge clk) disable iff (!rstn)
         next_req |=> (requested_priority_level == $past(prio[int'(next_idx)*2 +: 2]));
   endproperty
   a_lvl_match: assert property (p_lvl_match) else $error("level differs from winner priority");

   sequence s_pick_agg;
      next_req && !mode[next_idx[9:5]];
   endsequence
   property p_agg_out;
      @(posedge clk) disable iff (!rstn) s_pick_agg |=> (irq_vector == $past(agg_vec[next_idx[9:5]]));
   endproperty
   a_agg_out: assert property (p_agg_out) else $error("group offset not presented");

   sequence s_pick_dis;
      next_req && mode[next_idx[9:5]];
   endsequence
   property p_dis_out;
      @(posedge clk) disable iff (!rstn) s_pick_dis |=> (irq_vector == $past(src_vec[next_idx]));
   endproperty
   a_dis_out: assert property (p_dis_out) else $error("source offset not presented");

   property p_mode_wr;
      @(posedge clk) disable iff (!rstn)
         (wr_grp && grp_off == via_pkg::OFF_MODE && wb_sel_i[0]) |=> (mode[$past(grp_sel)] == $past(wb_dat_i[0]));
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("mode write lost");

   property p_en_clr;
      @(posedge clk) disable iff (!rstn) (wr_grp && grp_off == via_pkg::OFF_EN_CLR) |=>
         ((enable[int'($past(grp_sel))*GB +: GB] & $past(wb_dat_i & wmask)) == '0);
   endproperty
   a_en_clr: assert property (p_en_clr) else $error("enable clear did not take effect");

   property p_stat_clr;
      @(posedge clk) disable iff (!rstn) (|clr_flat) |=> ((status & $past(clr_flat & ~src_sync)) == '0);
   endproperty
   a_stat_clr: assert property (p_stat_clr) else $error("status clear did not take effect");

   property p_sticky;
      @(posedge clk) disable iff (!rstn)
         (clr_flat == '0) |=> ((($past(status) & ~via_pkg::AUTO_MAP) & ~status) == '0);
   endproperty
   a_sticky: assert property (p_sticky) else $error("status bit dropped without clear");

   sequence s_agg_wr;
      wr_grp && grp_off == via_pkg::OFF_AGG_VEC && wb_sel_i == 4'hf;
   endsequence
   property p_agg_wr;
      @(posedge clk) disable iff (!rstn)
         s_agg_wr |=> (agg_vec[$past(grp_sel)] == $past(wb_dat_i[via_pkg::VEC_W-1:0]));
   endproperty
   a_agg_wr: assert property (p_agg_wr) else $error("group offset write lost");

   sequence s_vec_wr;
      wr && wb_adr_i[13:12] == via_pkg::REGION_VEC && wb_sel_i == 4'hf;
   endsequence
   property p_vec_wr;
      @(posedge clk) disable iff (!rstn)
         s_vec_wr |=> (src_vec[$past(wb_adr_i[11:2])] == $past(wb_dat_i[via_pkg::VEC_W-1:0]));
   endproperty
   a_vec_wr: assert property (p_vec_wr) else $error("source offset write lost");

   property p_wake_off;
      @(posedge clk) disable iff (!rstn) !(|(enable & via_pkg::WAKE_MAP)) |-> !wake_event;
   endproperty
   a_wake_off: assert property (p_wake_off) else $error("wake without enabled wake source");

   property p_wake_on;
      @(posedge clk) disable iff (!rstn) ((src_event & enable & via_pkg::WAKE_MAP) != '0) |-> wake_event;
   endproperty
   a_wake_on: assert property (p_wake_on) else $error("wake-capable source gave no wake");
endmodule
`default_nettype wire

/* File: dv/via_core_model.sv */
// Behavioural stand-in for the processor's external interrupt port.
// Assumes the aggregator's request, offset and level outputs are registered in the clk domain.
`timescale 1ns/1ps
`default_nettype none
module via_core_model #(
   parameter logic [31:0] EXCEPTION_BASE = 32'h0004_0000
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic irq_req,
   input wire logic [via_pkg::VEC_W-1:0] irq_vector,
   input wire logic [via_pkg::PRIO_W-1:0] requested_priority_level,
   output logic [31:0] handler_addr,
   output logic [via_pkg::PRIO_W-1:0] taken_level
);
   // The base sits on a 256k boundary, so the offset is appended with no carry into the base
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         handler_addr <= 32'h0;
         taken_level <= 2'h0;
      end else if (irq_req) begin
         handler_addr <= EXCEPTION_BASE | {14'h0, irq_vector};
         taken_level <= requested_priority_level;
      end
   end
endmodule
`default_nettype wire

/* File: dv/vectored_interrupt_aggregator_tb_top.sv */
// Self-checking bench: Wishbone register tasks plus source-line stimulus of the aggregator.
// Assumes via_pkg, via_top and via_core_model are compiled first; the bench is the only bus master.
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_aggregator_tb_top;
   logic clk, rstn, cyc, stb, we, ack, irq, wake;
   logic [3:0] sel;
   logic [13:0] adr;
   logic [31:0] dwr, drd, rdat, hadr;
   logic [via_pkg::NUM_SRC-1:0] src;
   logic [17:0] vec;
   logic [1:0] lvl, tlvl;
   int n_fail, cmp_count, cyc_n;

   via_top dut_u (.clk(clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(drd), .wb_ack_o(ack), .src_event(src), .irq_req(irq),
      .irq_vector(vec), .requested_priority_level(lvl), .wake_event(wake));
   via_core_model core_u (.clk(clk), .rstn(rstn), .irq_req(irq), .irq_vector(vec),
      .requested_priority_level(lvl), .handler_addr(hadr), .taken_level(tlvl));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         n_fail++;
         $display("mismatch %0t timeout", $time);
         stop_test();
      end
   end

   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk_reg(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %0t read %h expected %h", $time, g, e);
      end
   endtask

   task automatic chk_pin(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %0t output %h expected %h", $time, g, e);
      end
   endtask

   // Request held until ack is sampled high; read data taken at that same edge
   task automatic wb(input logic w, input logic [13:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dwr <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      rdat = drd;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask

   task automatic rd(input logic [13:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      chk_reg(rdat, e);
   endtask

   task automatic ev(input int k, input logic v);
      @(posedge clk);
      src[k] <= v;
   endtask

   task automatic look(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   function automatic logic [13:0] ga(input int g, input logic [4:0] o);
      return 14'(g * 32) + 14'(o);
   endfunction

   initial begin
      rstn = 1'b0;
      cyc = 1'b0;
      stb = 1'b0;
      we = 1'b0;
      sel = 4'h0;
      adr = 14'h0;
      dwr = 32'h0;
      src = '0;
      n_fail = 0;
      cmp_count = 0;
      cyc_n = 0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      rd(via_pkg::ADDR_STATUS, 32'h0);
      rd(ga(0, 5'h04), 32'h0);
      // Unmapped place: write dropped, read gives zero
      wr(14'h3000, 32'hffff_ffff);
      rd(14'h3000, 32'h0);
      wr(ga(3, 5'h04), 32'h5);
      rd(ga(3, 5'h08), 32'h5);
      wr(ga(3, 5'h08), 32'h1);
      rd(ga(3, 5'h04), 32'h4);
      wr(ga(3, 5'h14), 32'h100);
      wr(ga(3, 5'h18), 32'h20);
      ev(97, 1'b1);
      ev(98, 1'b1);
      look(1);
      chk_pin(32'(irq), 32'h0);
      look(6);
      chk_pin(32'(vec), 32'h100);
      chk_pin(32'(lvl), 32'h2);
      rd(ga(3, 5'h00), 32'h6);
      rd(ga(3, 5'h0c), 32'h4);
      rd(via_pkg::ADDR_STATUS, 32'h8200_0100);
      chk_pin(hadr, 32'h0004_0100);
      // Equal level in a later group must not take over
      wr(ga(7, 5'h04), 32'h1);
      wr(ga(7, 5'h18), 32'h2);
      wr(ga(7, 5'h14), 32'h300);
      ev(224, 1'b1);
      look(6);
      chk_pin(32'(vec), 32'h100);
      wr(ga(5, 5'h04), 32'h1);
      wr(ga(5, 5'h18), 32'h3);
      wr(ga(5, 5'h10), 32'h1);
      wr(ga(5, 5'h14), 32'h3ff);
      wr(14'h1280, 32'h2a0);
      ev(160, 1'b1);
      look(6);
      chk_pin(32'(vec), 32'h2a0);
      chk_pin(32'(tlvl), 32'h3);
      rd(ga(5, 5'h10), 32'h1);
      @(posedge clk);
      src <= '0;
      look(4);
      wr(ga(3, 5'h00), 32'hffff_ffff);
      wr(ga(5, 5'h00), 32'hffff_ffff);
      wr(ga(7, 5'h00), 32'hffff_ffff);
      look(3);
      chk_pin({irq, 11'h0, lvl, vec}, 32'h0);
      wr(ga(22, 5'h04), 32'h1);
      chk_pin(32'(wake), 32'h0);
      ev(704, 1'b1);
      look(1);
      chk_pin(32'(wake), 32'h1);
      look(6);
      chk_pin(32'(irq), 32'h0);
      ev(704, 1'b0);
      look(6);
      rd(ga(22, 5'h00), 32'h0);
      wr(ga(16, 5'h04), 32'h100);
      ev(520, 1'b1);
      look(1);
      chk_pin(32'(wake), 32'h1);
      look(6);
      chk_pin(32'(irq), 32'h1);
      rd(ga(16, 5'h00), 32'h100);
      ev(520, 1'b0);
      look(4);
      wr(ga(16, 5'h00), 32'h100);
      wr(ga(16, 5'h08), 32'h100);
      look(3);
      chk_pin(32'(irq), 32'h0);
      wr(ga(9, 5'h04), 32'hc000_0000);
      ev(319, 1'b1);
      look(1);
      chk_pin(32'(wake), 32'h0);
      ev(318, 1'b1);
      look(1);
      chk_pin(32'(wake), 32'h1);
      // Upper priority word: source 30 of group 9 raised to the top level
      wr(ga(9, 5'h1c), 32'h3000_0000);
      rd(ga(9, 5'h1c), 32'h3000_0000);
      look(2);
      chk_pin(32'(lvl), 32'h3);
      ev(1023, 1'b1);
      look(6);
      rd(ga(31, 5'h00), 32'h8000_0000);
      // Clear while the line is still high: the new event wins
      wr(ga(31, 5'h00), 32'h8000_0000);
      rd(ga(31, 5'h00), 32'h8000_0000);
      stop_test();
   end
endmodule
`default_nettype wire
